// ==== rtl/hrap_regbank.v ====
// 256 x 8 register storage with one write and one read port
// assumes writes are single-cycle pulses from the access port
`timescale 1ns/1ns
module hrap_regbank (
    input wire clock,          // system clock
    input wire wrEn,           // write pulse
    input wire [7:0] wrAddr,   // write address
    input wire [7:0] wrData,   // write data
    input wire [7:0] rdAddr,   // read address
    output wire [7:0] rdData   // read data, combinational
);
    reg [7:0] memArray [0:255];

    always @(posedge clock) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
    end

    assign rdData = memArray[rdAddr];
endmodule

// ==== rtl/hrap_sync.v ====
// two-flop synchroniser for a bundle of pin inputs
// assumes inputs are asynchronous to clock; INIT gives the idle pin levels
`timescale 1ns/1ns
module hrap_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clock,          // system clock
    input wire rstn,           // asynchronous reset, active low
    input wire [W-1:0] d,      // raw pin levels
    output wire [W-1:0] q      // synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gBit
            reg s1_reg;
            reg s2_reg;
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    s1_reg <= INIT[i];
                    s2_reg <= INIT[i];
                end else begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                end
            end
            assign q[i] = s2_reg;
        end
    endgenerate
endmodule

// ==== rtl/hrap_top.v ====
// host register access port: serial frame and parallel bus into the register bank
// assumes all pin inputs are asynchronous; host serial clock is sampled by clock
`timescale 1ns/1ns
`include "hrap_regs.vh"
module hrap_top (
    input wire clock,                 // 125 MHz system clock
    input wire rstn,                  // asynchronous reset, active low
    input wire serialParallelSelect,  // high selects the serial port
    input wire serialClk,             // host serial clock
    input wire serialSelN,            // serial select, active low
    input wire serialInLine,          // serial data in
    output wire serialOutLine,        // serial data out
    output wire serialOutOeN,         // serial out enable, low drives
    input wire [1:0] hostProtocolSelect, // parallel bus style
    input wire parSelN,               // parallel select, active low
    input wire addrLatchEn,           // address latch enable, active high
    input wire readStrobeN,           // read strobe or data strobe, active low
    input wire writeStrobeN,          // write strobe or direction line
    input wire [7:0] addrIn,          // parallel address bus
    input wire [7:0] dataIn,          // data bus, pin level
    output wire [7:0] dataOut,        // data bus, driven value
    output wire dataOeN,              // data bus enable, low drives
    output wire readyN,               // cycle complete, active low
    output wire regWrStrobe,          // register write pulse to the core
    output wire [7:0] regWrAddr,      // register write address
    output wire [7:0] regWrData       // register write data
);
    // data strobe style when mode bit 0 is set
    function isDsMode;
        input [1:0] mode;
        begin
            isDsMode = (mode == `HRAP_MODE_DS_ASYNC) || (mode == `HRAP_MODE_DS_SYNC);
        end
    endfunction

    wire [`HRAP_SYNC_W-1:0] rawPins;
    wire [`HRAP_SYNC_W-1:0] syncPins;
    wire serMode;
    wire [1:0] modeS;
    wire sclkS;
    wire csS;
    wire sdiS;
    wire aleS;
    wire rdS;
    wire wrS;
    wire parCsS;
    wire [7:0] addrS;
    wire [7:0] dataS;

    assign rawPins = {serialParallelSelect, hostProtocolSelect, serialClk, serialSelN,
                      serialInLine, addrLatchEn, readStrobeN, writeStrobeN, parSelN,
                      addrIn, dataIn};

    hrap_sync #(
        .W(`HRAP_SYNC_W),
        .INIT(`HRAP_SYNC_INIT)
    ) uSync (
        .clock(clock),
        .rstn(rstn),
        .d(rawPins),
        .q(syncPins)
    );

    assign serMode = syncPins[25];
    assign modeS = syncPins[24:23];
    assign sclkS = syncPins[22];
    assign csS = syncPins[21];
    assign sdiS = syncPins[20];
    assign aleS = syncPins[19];
    assign rdS = syncPins[18];
    assign wrS = syncPins[17];
    assign parCsS = syncPins[16];
    assign addrS = syncPins[15:8];
    assign dataS = syncPins[7:0];

    // edge history
    reg sclkPrev_reg;
    reg csPrev_reg;
    reg alePrev_reg;
    reg rdPrev_reg;
    reg wrPrev_reg;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
            alePrev_reg <= 1'b0;
            rdPrev_reg <= 1'b1;
            wrPrev_reg <= 1'b1;
        end else begin
            sclkPrev_reg <= sclkS;
            csPrev_reg <= csS;
            alePrev_reg <= aleS;
            rdPrev_reg <= rdS;
            wrPrev_reg <= wrS;
        end
    end

    wire sclkRise = sclkS & ~sclkPrev_reg;
    wire sclkFall = ~sclkS & sclkPrev_reg;
    wire csRise = csS & ~csPrev_reg;
    wire aleFall = ~aleS & alePrev_reg;
    wire rdFall = ~rdS & rdPrev_reg;
    wire wrFall = ~wrS & wrPrev_reg;

    // serial frame engine
    reg [4:0] bitCnt_reg;
    reg [7:0] frameAddr_reg;
    reg rwBit_reg;
    reg [7:0] frameData_reg;
    reg [7:0] rdShift_reg;
    reg sdo_reg;
    reg sdoOeN_reg;
    wire [7:0] bankRdData;
    wire [4:0] outIdx = bitCnt_reg - `HRAP_OUT_FIRST;
    wire serCommit;

    // write only after a full frame, on select rise
    assign serCommit = serMode & csRise & (bitCnt_reg == `HRAP_FRAME_BITS)
                       & (rwBit_reg == `HRAP_RW_WRITE);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bitCnt_reg <= 5'h00;
            frameAddr_reg <= 8'h00;
            rwBit_reg <= 1'b0;
            frameData_reg <= 8'h00;
            rdShift_reg <= 8'h00;
            sdo_reg <= 1'b0;
            sdoOeN_reg <= 1'b1;
        end else if (!serMode || csS) begin
            // deselected: restart counting, release output
            bitCnt_reg <= 5'h00;
            sdoOeN_reg <= 1'b1;
        end else if (sclkRise) begin
            if (bitCnt_reg < `HRAP_RW_POS) begin
                frameAddr_reg[bitCnt_reg[2:0]] <= sdiS;
            end else if (bitCnt_reg == `HRAP_RW_POS) begin
                rwBit_reg <= sdiS;
            end else if (bitCnt_reg == `HRAP_FILL_END) begin
                rdShift_reg <= bankRdData; // filler value itself unused
            end else if (bitCnt_reg >= `HRAP_DATA_FIRST &&
                         bitCnt_reg < `HRAP_FRAME_BITS) begin
                frameData_reg[bitCnt_reg[2:0]] <= sdiS;
            end
            if (bitCnt_reg != `HRAP_CNT_OVER) begin
                bitCnt_reg <= bitCnt_reg + 5'h01;
            end
        end else if (sclkFall && rwBit_reg == `HRAP_RW_READ &&
                     bitCnt_reg >= `HRAP_OUT_FIRST &&
                     bitCnt_reg <= `HRAP_FRAME_BITS) begin
            sdo_reg <= rdShift_reg[outIdx[2:0]];
            sdoOeN_reg <= 1'b0;
        end
    end

    assign serialOutLine = sdo_reg;
    assign serialOutOeN = sdoOeN_reg;

    // parallel bus engine
    reg [1:0] pState_reg;
    reg [7:0] parAddr_reg;
    reg [7:0] dataOut_reg;
    reg dataOeN_reg;
    reg readyN_reg;

    wire dsMode = isDsMode(modeS);
    wire parStart = dsMode ? rdFall : (rdFall | wrFall);
    wire parIsRead = isDsMode(modeS) ? wrS : rdFall;
    wire strobeIdle = dsMode ? rdS : (rdS & wrS);
    wire parTaken = ~serMode & ~parCsS & parStart
                    & (pState_reg == `HRAP_P_IDLE);
    wire [7:0] liveAddr = aleS ? addrS : parAddr_reg;
    wire parCommit = parTaken & ~parIsRead;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pState_reg <= `HRAP_P_IDLE;
            parAddr_reg <= 8'h00;
            dataOut_reg <= 8'h00;
            dataOeN_reg <= 1'b1;
            readyN_reg <= 1'b1;
        end else if (serMode) begin
            pState_reg <= `HRAP_P_IDLE;
            dataOeN_reg <= 1'b1;
            readyN_reg <= 1'b1;
        end else begin
            if (aleFall) begin
                parAddr_reg <= addrS;
            end
            case (pState_reg)
                `HRAP_P_IDLE: begin
                    if (parTaken) begin
                        // latch enable tied high: address taken live
                        parAddr_reg <= liveAddr;
                        if (parIsRead) begin
                            pState_reg <= `HRAP_P_READ;
                        end else begin
                            readyN_reg <= 1'b0;
                            pState_reg <= `HRAP_P_DONE;
                        end
                    end
                end
                `HRAP_P_READ: begin
                    dataOut_reg <= bankRdData;
                    dataOeN_reg <= 1'b0;
                    readyN_reg <= 1'b0;
                    pState_reg <= `HRAP_P_DONE;
                end
                `HRAP_P_DONE: begin
                    if (strobeIdle || parCsS) begin
                        dataOeN_reg <= 1'b1;
                        readyN_reg <= 1'b1;
                        pState_reg <= `HRAP_P_IDLE;
                    end
                end
                default: begin
                    pState_reg <= `HRAP_P_IDLE;
                end
            endcase
        end
    end

    assign dataOut = dataOut_reg;
    assign dataOeN = dataOeN_reg;
    assign readyN = readyN_reg;

    // write port shared by both engines
    reg wrEn_reg;
    reg [7:0] wrAddr_reg;
    reg [7:0] wrData_reg;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrEn_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            wrData_reg <= 8'h00;
        end else begin
            wrEn_reg <= serCommit | parCommit;
            if (serCommit) begin
                wrAddr_reg <= frameAddr_reg;
                wrData_reg <= frameData_reg;
            end else if (parCommit) begin
                wrAddr_reg <= liveAddr;
                wrData_reg <= dataS;
            end
        end
    end

    wire [7:0] bankRdAddr = serMode ? frameAddr_reg : parAddr_reg;

    hrap_regbank uBank (
        .clock(clock),
        .wrEn(wrEn_reg),
        .wrAddr(wrAddr_reg),
        .wrData(wrData_reg),
        .rdAddr(bankRdAddr),
        .rdData(bankRdData)
    );

    assign regWrStrobe = wrEn_reg;
    assign regWrAddr = wrAddr_reg;
    assign regWrData = wrData_reg;
endmodule

// ==== shared/hrap_regs.vh ====
// constants of the host register access port: frame layout, modes, states
// assumes inclusion by the top rtl file of the block
//
// Overview of operation
// - serial frame is 24 bits, sampled on clock rise
// - nothing committed before all 24 bits arrive
// - serial output changes only on clock fall
// - clocks 1-8 carry address, bit 0 first
// - ninth bit: 0 writes, 1 reads
// - clocks 10-16 are ignored filler bits
// - clocks 17-24 carry write data, lsb first
// - write lands in register when select rises
// - read data out on clocks 17-24
// - serial output released after select rises
// - protocol select bit 0 picks separate or data strobe style; sync styles act as async
// - 8-bit data bus, direct 8-bit address
// - parallel accesses only while select is low
// - address captured on latch enable fall
// - read strobe fall starts a read
// - write strobe fall starts a write
// - ready low marks cycle complete
// - parallel default, serial when select pin high
// - data strobe mode: direction high reads
`ifndef HRAP_REGS_VH
`define HRAP_REGS_VH

`define HRAP_FRAME_BITS 5'h18
`define HRAP_CNT_OVER 5'h19
`define HRAP_RW_POS 5'h08
`define HRAP_FILL_END 5'h0F
`define HRAP_DATA_FIRST 5'h10
`define HRAP_OUT_FIRST 5'h11
`define HRAP_RW_WRITE 1'h0
`define HRAP_RW_READ 1'h1

`define HRAP_MODE_SEP_ASYNC 2'h0
`define HRAP_MODE_DS_ASYNC 2'h1
`define HRAP_MODE_SEP_SYNC 2'h2
`define HRAP_MODE_DS_SYNC 2'h3

`define HRAP_P_IDLE 2'h0
`define HRAP_P_READ 2'h1
`define HRAP_P_DONE 2'h2

`define HRAP_SYNC_W 26
`define HRAP_SYNC_INIT 26'h027_0000

`endif

// ==== verification/hrap_host_model.sv ====
// host model driving serial frames on the link pins
// assumes the 8 ns bench clock; serial half period is 10 clocks
`timescale 1ns/1ns
module hrap_host_model (
    input wire clock,          // bench clock
    output logic serialClk,    // serial clock, pulsed once with select high before each frame
    output logic serialSelN,   // serial select
    output logic serialInLine, // serial data in
    input wire serialOutLine,  // device serial out
    input wire serialOutOeN    // device out enable
);
    logic junk = 1'b0;
    wire sdoLevel = serialOutOeN ? junk : serialOutLine;
    initial begin
        serialClk = 1'b0;
        serialSelN = 1'b1;
        serialInLine = 1'b0;
    end
    // released line shows a toggling level
    always @(posedge clock) begin
        junk <= ~junk;
    end
    task automatic half();
        repeat (10) @(posedge clock);
    endtask
    task automatic frame(input logic [23:0] b, input int n, output logic [7:0] rd);
        rd = 8'h00;
        serialClk <= 1'b1;
        half();
        serialClk <= 1'b0;
        half();
        serialSelN <= 1'b0;
        for (int i = 0; i < n; i++) begin
            serialInLine <= b[i % 24];
            half();
            if (i > 16 && i < 25) begin
                rd[i - 17] = sdoLevel;
            end
            serialClk <= 1'b1;
            half();
            serialClk <= 1'b0;
        end
        half();
        if (n > 23) begin
            rd[7] = sdoLevel;
        end
        serialSelN <= 1'b1;
        serialInLine <= ~serialInLine;
        half();
    endtask
endmodule

// ==== verification/hrap_top_monitor.sv ====
// checker of hrap_top port timing, bound to the top module
// assumes 125 MHz clock and a host serial half period of 10 clocks
`timescale 1ns/1ns
module hrap_top_monitor (
    input wire clock,                // system clock
    input wire rstn,                 // reset, active low
    input wire serialParallelSelect, // high selects serial
    input wire serialClk,            // host serial clock
    input wire serialSelN,           // serial select
    input wire serialOutLine,        // serial data out
    input wire serialOutOeN,         // serial out enable
    input wire parSelN,              // parallel select
    input wire readStrobeN,          // read or data strobe
    input wire dataOeN,              // data bus enable
    input wire readyN,               // cycle complete
    input wire regWrStrobe           // write pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_ser_idle;
        serialSelN [*6];
    endsequence
    sequence s_par_idle;
        parSelN [*6];
    endsequence
    sequence s_rd_start;
        $fell(readStrobeN) && !parSelN && !serialParallelSelect && readyN;
    endsequence
    a_no_early_wr: assert property (regWrStrobe && serialParallelSelect |-> $past(serialSelN, 3))
        else $error("serial write before select rose");
    a_wr_pulse_one: assert property (regWrStrobe |=> !regWrStrobe)
        else $error("write pulse longer than one cycle");
    a_par_wr_sel: assert property (regWrStrobe && !serialParallelSelect |-> !$past(parSelN, 4) && !readyN)
        else $error("parallel write without select or ready");
    a_sdo_on_fall: assert property (!serialOutOeN && $changed(serialOutLine) |-> !$past(serialClk, 3))
        else $error("serial out changed away from clock fall");
    a_sdo_release: assert property (s_ser_idle |-> serialOutOeN)
        else $error("serial out driven after select rose");
    a_par_release: assert property (s_par_idle |-> readyN && dataOeN)
        else $error("ready or data driven while deselected");
    a_rd_drive: assert property (!dataOeN |-> !readyN)
        else $error("data bus driven without ready");
    a_par_no_sdo: assert property (!serialParallelSelect && !$past(serialParallelSelect, 4) |-> serialOutOeN)
        else $error("serial out driven in parallel mode");
    a_rd_ready_bound: assert property (s_rd_start |-> ##[3:8] !readyN)
        else $error("ready late after strobe");
endmodule

bind hrap_top hrap_top_monitor u_hrap_top_monitor (.clock(clock), .rstn(rstn),
    .serialParallelSelect(serialParallelSelect), .serialClk(serialClk),
    .serialSelN(serialSelN), .serialOutLine(serialOutLine), .serialOutOeN(serialOutOeN),
    .parSelN(parSelN), .readStrobeN(readStrobeN), .dataOeN(dataOeN), .readyN(readyN),
    .regWrStrobe(regWrStrobe));

// ==== verification/testbench.sv ====
// self-checking bench of hrap_top: serial frames and parallel bus
// assumes the host model drives the serial pins; parallel pins driven here
`timescale 1ns/1ns
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic serialParallelSelect = 1'b1;
    logic [1:0] hostProtocolSelect = 2'h0;
    logic parSelN = 1'b1;
    logic addrLatchEn = 1'b0;
    logic readStrobeN = 1'b1;
    logic writeStrobeN = 1'b1;
    logic [7:0] addrIn = 8'h00;
    logic [7:0] dataDrv = 8'h00;
    wire serialClk, serialSelN, serialInLine, serialOutLine, serialOutOeN;
    wire dataOeN, readyN, regWrStrobe;
    wire [7:0] dataOut, regWrAddr, regWrData;
    wire [7:0] dataIn = dataOeN ? dataDrv : dataOut;
    int n_mismatch = 0;
    int comparisons = 0;
    int nWr = 0;
    logic [7:0] mem [256];
    logic [31:0] rnd = 32'h1919;
    logic [7:0] rd;
    logic [7:0] ad;
    logic [15:0] lastWr = 16'h0000;
    hrap_top u_hrap_top (.clock(clock), .rstn(rstn),
        .serialParallelSelect(serialParallelSelect), .serialClk(serialClk),
        .serialSelN(serialSelN), .serialInLine(serialInLine), .serialOutLine(serialOutLine),
        .serialOutOeN(serialOutOeN), .hostProtocolSelect(hostProtocolSelect),
        .parSelN(parSelN), .addrLatchEn(addrLatchEn), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .readyN(readyN), .regWrStrobe(regWrStrobe),
        .regWrAddr(regWrAddr), .regWrData(regWrData));
    hrap_host_model u_hrap_host_model (.clock(clock), .serialClk(serialClk),
        .serialSelN(serialSelN), .serialInLine(serialInLine),
        .serialOutLine(serialOutLine), .serialOutOeN(serialOutOeN));
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (regWrStrobe === 1'b1) begin
            nWr <= nWr + 1;
            lastWr <= {regWrAddr, regWrData};
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic ser(input logic rw, input logic [7:0] a, input logic [7:0] d, input int n);
        int w0;
        logic ok;
        w0 = nWr;
        ok = n == 24 && serialParallelSelect;
        rnd = lfsr(rnd);
        u_hrap_host_model.frame({d, rnd[6:0], rw, a}, n, rd);
        if (rw)
            check("serial read", 16'(rd), 16'(mem[a]));
        else
            check("serial writes", 16'(nWr - w0), 16'(ok));
        if (!rw && ok) begin
            check("serial write", lastWr, {a, d});
            mem[a] = d;
        end
    endtask
    task automatic par(input logic [1:0] m, input logic rw, input logic cs,
        input logic [7:0] a, input logic [7:0] d);
        int w0;
        int k;
        w0 = nWr;
        rnd = lfsr(rnd);
        hostProtocolSelect <= m;
        parSelN <= !cs;
        addrIn <= a;
        dataDrv <= d;
        addrLatchEn <= 1'b1;
        writeStrobeN <= m[0] ? rw : 1'b1;
        repeat (4) @(posedge clock);
        // style 10 keeps latch enable high: address taken live
        addrLatchEn <= (m == 2'h2);
        repeat (8) @(posedge clock);
        if (m != 2'h2)
            addrIn <= rnd[7:0];
        if (m[0] || rw)
            readStrobeN <= 1'b0;
        else
            writeStrobeN <= 1'b0;
        k = 0;
        while (readyN !== 1'b0 && k < 12) begin
            @(posedge clock);
            k++;
        end
        @(posedge clock);
        check("ready", 16'(readyN), 16'(!cs));
        if (cs && rw)
            check("parallel read", 16'({dataOeN, dataOut}), 16'(mem[a]));
        if (!rw)
            check("parallel writes", 16'(nWr - w0), 16'(cs));
        if (cs && !rw) begin
            check("parallel write", lastWr, {a, d});
            mem[a] = d;
        end
        readStrobeN <= 1'b1;
        writeStrobeN <= 1'b1;
        parSelN <= 1'b1;
        repeat (8) @(posedge clock);
        check("ready release", 16'({dataOeN, readyN}), 16'h0003);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            ad = rnd[7:0];
            ser(1'b0, ad, rnd[15:8], 24);
            ser(1'b1, ad, 8'h00, 24);
        end
        ser(1'b0, ad, 8'h5A, 23);
        ser(1'b0, ad, 8'hA5, 25);
        ser(1'b1, ad, 8'h00, 24);
        serialParallelSelect <= 1'b0;
        repeat (4) @(posedge clock);
        ser(1'b0, ad, 8'h3C, 24);
        for (int m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            ad = rnd[7:0];
            par(2'(m), 1'b0, 1'b1, ad, rnd[15:8]);
            par(2'(m), 1'b0, 1'b0, ad, 8'hFF);
            par(2'(m), 1'b1, 1'b1, ad, 8'h00);
        end
        serialParallelSelect <= 1'b1;
        repeat (4) @(posedge clock);
        ser(1'b1, ad, 8'h00, 24);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end
endmodule
